// *** src/srt_pkg.sv ***
package srt_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [11:0] OFF_PRESCALE = 12'h000;
  localparam logic [11:0] OFF_RELOAD = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h008;
  localparam logic [11:0] OFF_COUNT = 12'h00C;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h014;

  // Prescale field
  localparam int PRESC_W = 3;
  localparam logic [2:0] PRESC_RST = 3'h0;
  localparam logic [2:0] PRESC_CODE_MAX = 3'h5;
  localparam int PRESC_DIV_W = 5;

  // Reload register
  localparam int RELOAD_W = 16;
  localparam logic [15:0] RELOAD_RST = 16'hFFFF;

  // Control/status bit positions
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_TC = 1;
  localparam int CTRL_IRQ_EN = 2;
  localparam int CTRL_WD_FLAG = 3;
  localparam int CTRL_FREEZE = 4;
  localparam int CTRL_W = 5;

  // Interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_UNDERFLOW = 0;
  localparam int IRQ_RESTART_DONE = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;

  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : srt_pkg

// *** src/srt_prescaler.sv ***
module srt_prescaler #(
  parameter int DIV_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow_clk,
  input wire logic [srt_pkg::PRESC_W-1:0] prescale_select,
  output logic prescaled_tick
);
  import srt_pkg::*;

  if (DIV_W < 5) begin : g_bad_div
    $error("srt_prescaler: DIV_W too small for divide by 32");
  end

  logic slow_q;
  logic [DIV_W-1:0] div_cnt;
  logic next_slow_q;
  logic [DIV_W-1:0] next_div_cnt;
  logic next_tick;
  logic slow_rise;
  logic [DIV_W-1:0] sel_mask;

  // Low bits that must be all ones for the selected divisor
  function automatic logic [DIV_W-1:0] div_mask(input logic [PRESC_W-1:0] sel);
    logic [DIV_W-1:0] m;
    m = '0;
    for (int i = 0; i < DIV_W; i++) begin
      m[i] = (i < int'(sel));
    end
    return m;
  endfunction : div_mask

  always_comb begin
    next_slow_q = slow_clk;
    slow_rise = slow_clk & ~slow_q;
    sel_mask = div_mask(prescale_select);
    next_div_cnt = slow_rise ? div_cnt + 1'b1 : div_cnt;
    next_tick = slow_rise && ((div_cnt & sel_mask) == sel_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_q <= 1'b0;
      div_cnt <= '0;
      prescaled_tick <= 1'b0;
    end else begin
      slow_q <= next_slow_q;
      div_cnt <= next_div_cnt;
      prescaled_tick <= next_tick;
    end
  end

endmodule : srt_prescaler

// *** src/srt_counter.sv ***
module srt_counter #(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic restart,
  input wire logic [CNT_W-1:0] preset,
  output logic [CNT_W-1:0] count,
  output logic underflow_pulse,
  output logic zero_hit,
  output logic restart_done
);
  import srt_pkg::*;

  if (CNT_W < 2) begin : g_bad_cnt
    $error("srt_counter: CNT_W must be at least 2");
  end

  logic [CNT_W-1:0] next_count;
  logic next_underflow;
  logic next_zero_hit;
  logic next_restart_done;
  logic at_one;
  logic at_zero;

  always_comb begin
    at_one = (count == CNT_W'(1));
    at_zero = (count == '0);
    next_count = count;
    next_underflow = underflow_pulse;
    next_zero_hit = 1'b0;
    next_restart_done = 1'b0;
    if (tick) begin
      next_underflow = 1'b0;
      if (restart) begin
        next_count = preset;
        next_restart_done = 1'b1;
      end else if (at_zero) begin
        next_count = preset;
      end else begin
        next_count = count - 1'b1;
        if (at_one) begin
          next_underflow = 1'b1;
          next_zero_hit = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= RELOAD_RST[CNT_W-1:0];
      underflow_pulse <= 1'b0;
      zero_hit <= 1'b0;
      restart_done <= 1'b0;
    end else begin
      count <= next_count;
      underflow_pulse <= next_underflow;
      zero_hit <= next_zero_hit;
      restart_done <= next_restart_done;
    end
  end

endmodule : srt_counter

// *** src/srt_timer.sv ***
module srt_timer #(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [srt_pkg::ADDR_W-1:0] paddr,
  input wire logic [srt_pkg::DATA_W-1:0] pwdata,
  output logic [srt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_clk,
  input wire logic debug_halt,
  output logic irq,
  output logic underflow_pulse,
  output logic prescaled_tick,
  output logic watchdog_event_flag
);
  import srt_pkg::*;

  if (CNT_W != RELOAD_W) begin : g_bad_width
    $error("srt_timer: CNT_W must match the reload register width");
  end

  if (CTRL_W > $bits(byte) || CTRL_FREEZE >= CTRL_W) begin : g_bad_ctrl
    $error("srt_timer: control bits must fit the byte-wide register");
  end

  if (PRESC_W > $bits(byte) || PRESC_DIV_W < int'(PRESC_CODE_MAX)) begin : g_bad_presc
    $error("srt_timer: prescale field must fit its byte and the divider");
  end

  if (IRQ_UNDERFLOW >= IRQ_W || IRQ_RESTART_DONE >= IRQ_W) begin : g_bad_irq
    $error("srt_timer: interrupt bits must lie inside the status register");
  end

  if ($bits(OFF_PRESCALE) != ADDR_W || DATA_W < CNT_W) begin : g_bad_bus
    $error("srt_timer: address or data width does not fit the register map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [PRESC_W-1:0] prescale_select;
  logic [RELOAD_W-1:0] timer_reload;
  logic restart;
  logic terminal_count_flag;
  logic timer_irq_enable;
  logic debug_freeze_enable;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  logic [PRESC_W-1:0] next_prescale_select;
  logic [RELOAD_W-1:0] next_timer_reload;
  logic next_restart;
  logic next_terminal_count_flag;
  logic next_timer_irq_enable;
  logic next_debug_freeze_enable;
  logic next_watchdog_event_flag;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] next_irq_mask;
  logic next_irq;

  logic [DATA_W-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic raw_tick;
  logic run_tick;
  logic frozen;
  logic [CNT_W-1:0] count;
  logic cnt_underflow;
  logic zero_hit;
  logic restart_done;

  logic setup;
  logic done;
  logic wr_done;
  logic rd_done;
  logic [IRQ_W-1:0] irq_set;

  // Register access strobes
  logic wr_prescale;
  logic wr_reload;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_ctrl;
  logic rd_status;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address match against one register
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] off);
    return addr == off;
  endfunction : hit

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    return hit(addr, OFF_PRESCALE) || hit(addr, OFF_RELOAD) || hit(addr, OFF_CTRL)
      || hit(addr, OFF_COUNT) || hit(addr, OFF_IRQ_STATUS) || hit(addr, OFF_IRQ_MASK);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // Tick generation and counter

  srt_prescaler #(
    .DIV_W(PRESC_DIV_W)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .slow_clk(slow_clk),
    .prescale_select(prescale_select),
    .prescaled_tick(raw_tick)
  );

  // Counting halts while the debugger holds the core and freeze is enabled
  assign frozen = debug_freeze_enable & debug_halt;
  assign run_tick = raw_tick & ~frozen;

  srt_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .tick(run_tick),
    .restart(restart),
    .preset(timer_reload),
    .count(count),
    .underflow_pulse(cnt_underflow),
    .zero_hit(zero_hit),
    .restart_done(restart_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus phases

  // Answer one cycle after setup; the access phase then ends at once
  assign setup = psel & ~penable;
  assign done = psel & penable & pready;
  assign wr_done = done & pwrite & ~pslverr;
  assign rd_done = done & ~pwrite & ~pslverr;

  // One strobe per register side effect, all taken at the access edge
  assign wr_prescale = wr_done & hit(paddr, OFF_PRESCALE);
  assign wr_reload = wr_done & hit(paddr, OFF_RELOAD);
  assign wr_ctrl = wr_done & hit(paddr, OFF_CTRL);
  assign wr_mask = wr_done & hit(paddr, OFF_IRQ_MASK);
  assign rd_ctrl = rd_done & hit(paddr, OFF_CTRL);
  assign rd_status = rd_done & hit(paddr, OFF_IRQ_STATUS);

  always_comb begin
    next_pready = setup;
    next_pslverr = setup & ~mapped(paddr);
    next_prdata = READ_ZERO;
    if (setup && !pwrite) begin
      // Unmapped addresses read as zero
      case (paddr)
        OFF_PRESCALE: begin
          next_prdata[PRESC_W-1:0] = prescale_select;
        end
        OFF_RELOAD: begin
          next_prdata[RELOAD_W-1:0] = timer_reload;
        end
        OFF_CTRL: begin
          next_prdata[CTRL_RESTART] = restart;
          next_prdata[CTRL_TC] = terminal_count_flag;
          next_prdata[CTRL_IRQ_EN] = timer_irq_enable;
          next_prdata[CTRL_WD_FLAG] = watchdog_event_flag;
          next_prdata[CTRL_FREEZE] = debug_freeze_enable;
        end
        OFF_COUNT: begin
          next_prdata[CNT_W-1:0] = count;
        end
        OFF_IRQ_STATUS: begin
          next_prdata[IRQ_W-1:0] = irq_status;
        end
        OFF_IRQ_MASK: begin
          next_prdata[IRQ_W-1:0] = irq_mask;
        end
        default: begin
          next_prdata = READ_ZERO;
        end
      endcase
    end else if (done) begin
      // Hold read data over the access edge
      next_prdata = prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= READ_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_comb begin
    next_prescale_select = prescale_select;
    next_timer_reload = timer_reload;
    next_timer_irq_enable = timer_irq_enable;
    next_debug_freeze_enable = debug_freeze_enable;
    next_watchdog_event_flag = watchdog_event_flag;
    next_irq_mask = irq_mask;
    if (wr_prescale) begin
      if (pwdata[PRESC_W-1:0] <= PRESC_CODE_MAX) begin
        next_prescale_select = pwdata[PRESC_W-1:0];
      end
    end
    if (wr_reload) begin
      // Counter keeps running; the value is used at the next reload
      next_timer_reload = pwdata[RELOAD_W-1:0];
    end
    if (wr_ctrl) begin
      next_timer_irq_enable = pwdata[CTRL_IRQ_EN];
      next_debug_freeze_enable = pwdata[CTRL_FREEZE];
      next_watchdog_event_flag = pwdata[CTRL_WD_FLAG];
    end
    if (wr_mask) begin
      next_irq_mask = pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_select <= PRESC_RST;
      timer_reload <= RELOAD_RST;
      timer_irq_enable <= 1'b0;
      debug_freeze_enable <= 1'b0;
      watchdog_event_flag <= 1'b0;
      irq_mask <= IRQ_RST;
    end else begin
      prescale_select <= next_prescale_select;
      timer_reload <= next_timer_reload;
      timer_irq_enable <= next_timer_irq_enable;
      debug_freeze_enable <= next_debug_freeze_enable;
      watchdog_event_flag <= next_watchdog_event_flag;
      irq_mask <= next_irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restart request

  always_comb begin
    // Writing zero to the restart position has no effect
    next_restart = restart & ~restart_done;
    if (wr_ctrl && pwdata[CTRL_RESTART]) begin
      next_restart = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart <= 1'b0;
    end else begin
      restart <= next_restart;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Terminal count flag

  always_comb begin
    // Clear only what the read reported, so a new zero is never lost
    next_terminal_count_flag = terminal_count_flag;
    if (rd_ctrl && !frozen) begin
      next_terminal_count_flag = terminal_count_flag & ~prdata[CTRL_TC];
    end
    if (zero_hit) begin
      next_terminal_count_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      terminal_count_flag <= 1'b0;
    end else begin
      terminal_count_flag <= next_terminal_count_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_UNDERFLOW] = zero_hit & timer_irq_enable;
    irq_set[IRQ_RESTART_DONE] = restart_done;
    next_irq_status = irq_status;
    if (rd_status) begin
      next_irq_status = irq_status & ~prdata[IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_set;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= IRQ_RST;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Visible timer signals

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underflow_pulse <= 1'b0;
      prescaled_tick <= 1'b0;
    end else begin
      underflow_pulse <= cnt_underflow;
      prescaled_tick <= raw_tick;
    end
  end

endmodule : srt_timer

// *** test/srt_timer_chk.sv ***
module srt_timer_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [srt_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic slow_clk,
  input wire logic irq,
  input wire logic underflow_pulse,
  input wire logic prescaled_tick,
  input wire logic watchdog_event_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  import srt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last slow clock rise and the last tick, saturating
  logic slow_d;
  logic [2:0] rise_age;
  logic [2:0] tick_age;
  logic [2:0] next_rise_age;
  logic [2:0] next_tick_age;

  always_comb begin
    next_rise_age = (rise_age == 3'h7) ? rise_age : rise_age + 3'h1;
    next_tick_age = (tick_age == 3'h7) ? tick_age : tick_age + 3'h1;
    if (slow_clk && !slow_d) begin
      next_rise_age = 3'h0;
    end
    if (prescaled_tick) begin
      next_tick_age = 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_d <= 1'b0;
      rise_age <= 3'h7;
      tick_age <= 3'h7;
    end else begin
      slow_d <= slow_clk;
      rise_age <= next_rise_age;
      tick_age <= next_tick_age;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property ((!pready && !$past(pready)) || (pready && pwrite) |->
    prdata == READ_ZERO)
    else $error("prdata not zero outside read");
  a_rdata_hold: assert property (pready && !pwrite |=> prdata == $past(prdata))
    else $error("read data not held after access");
  a_tick_from_edge: assert property (prescaled_tick |-> rise_age <= 3'h4)
    else $error("tick without slow clock rise");
  a_tick_single_pulse: assert property (prescaled_tick |=> !prescaled_tick)
    else $error("tick longer than one cycle");
  a_ufl_rise_tick: assert property ($rose(underflow_pulse) |-> tick_age <= 3'h4)
    else $error("underflow rose without tick");
  a_ufl_fall_tick: assert property ($fell(underflow_pulse) |-> tick_age <= 3'h4)
    else $error("underflow fell without tick");
  a_irq_fall_bus: assert property ($fell(irq) |->
    $past(psel && penable && pready) || $past(psel && penable && pready, 2))
    else $error("irq fell without bus access");
  a_wd_flag_write: assert property ($changed(watchdog_event_flag) |->
    $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
    else $error("watchdog flag changed without write");
endmodule : srt_timer_chk

bind srt_timer srt_timer_chk i_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .slow_clk(slow_clk),
  .irq(irq),
  .underflow_pulse(underflow_pulse),
  .prescaled_tick(prescaled_tick),
  .watchdog_event_flag(watchdog_event_flag)
);

// *** test/slow_tick_reload_timer_bench.sv ***
module slow_tick_reload_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import srt_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic slow_clk = 1'b0;
  logic slow_en = 1'b0;
  logic debug_halt = 1'b0;
  logic [1:0] sdiv = 2'h0;
  logic irq;
  logic underflow_pulse;
  logic prescaled_tick;
  logic watchdog_event_flag;
  logic uf_q = 1'b0;
  int tick_cnt = 0;
  int n_fail = 0;
  int checked = 0;

  srt_timer i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .slow_clk(slow_clk),
    .debug_halt(debug_halt),
    .irq(irq),
    .underflow_pulse(underflow_pulse),
    .prescaled_tick(prescaled_tick),
    .watchdog_event_flag(watchdog_event_flag)
  );

  always #5 pclk = ~pclk;

  // Slow clock of four pclk periods, stopped while slow_en is low
  always @(posedge pclk) begin
    if (slow_en) begin
      sdiv <= sdiv + 2'h1;
      if (sdiv[0]) begin
        slow_clk <= ~slow_clk;
      end
    end
    if (prescaled_tick === 1'b1) begin
      tick_cnt <= tick_cnt + 1;
    end
    uf_q <= underflow_pulse;
  end

  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  task wait_tick(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (prescaled_tick !== 1'b1);
  endtask : wait_tick

  task wait_uf;
    do begin
      @(posedge pclk);
    end while (!(underflow_pulse === 1'b1 && uf_q !== 1'b1));
  endtask : wait_uf

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [31:0] r;
    logic e;
    rd(OFF_PRESCALE, r);
    chk("prescale", r, 32'h0);
    rd(OFF_RELOAD, r);
    chk("reload", r, 32'h0000FFFF);
    rd(OFF_CTRL, r);
    chk("ctrl", r, 32'h0);
    rd(OFF_COUNT, r);
    chk("count", r, 32'h0000FFFF);
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk("unmapped", {e, r[30:0]}, 32'h80000000);
    wr(OFF_CTRL, 32'h08);
    @(posedge pclk);
    chk("wd_flag", {31'h0, watchdog_event_flag}, 32'h1);
    wr(OFF_CTRL, 32'h0);
  endtask : t_reset

  task t_prescale;
    logic [31:0] r;
    int n;
    wr(OFF_PRESCALE, 32'hFD);
    rd(OFF_PRESCALE, r);
    chk("presc_field", r, 32'h5);
    for (int c = 6; c < 8; c++) begin
      wr(OFF_PRESCALE, c);
      rd(OFF_PRESCALE, r);
      chk("presc_rsvd", r, 32'h5);
    end
    slow_en <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      wr(OFF_PRESCALE, c);
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      chk("tick_gap", n, 32'h4 << c);
    end
  endtask : t_prescale

  task t_period;
    logic [31:0] r;
    int t0;
    wr(OFF_PRESCALE, 32'h3);
    wr(OFF_RELOAD, 32'h2);
    wr(OFF_CTRL, 32'h5);
    for (int i = 0; i < 50; i++) begin
      rd(OFF_CTRL, r);
      if (r[0] === 1'b0) begin
        break;
      end
    end
    chk("restart_clr", r[0], 32'h0);
    wait_uf;
    t0 = tick_cnt;
    wait_uf;
    chk("period", tick_cnt - t0, 32'h3);
    rd(OFF_CTRL, r);
    chk("tc_set", r[1], 32'h1);
    rd(OFF_CTRL, r);
    chk("tc_clr", r[1], 32'h0);
    wait_uf;
    wr(OFF_RELOAD, 32'h5);
    rd(OFF_COUNT, r);
    chk("no_restart", r <= 32'h2, 32'h1);
    wait_uf;
    t0 = tick_cnt;
    wait_uf;
    chk("new_period", tick_cnt - t0, 32'h6);
  endtask : t_period

  task t_freeze;
    logic [31:0] r;
    logic [31:0] c0;
    wr(OFF_CTRL, 32'h14);
    debug_halt <= 1'b1;
    rd(OFF_COUNT, c0);
    repeat (100) @(posedge pclk);
    rd(OFF_COUNT, r);
    chk("frozen_count", r, c0);
    rd(OFF_CTRL, r);
    rd(OFF_CTRL, r);
    chk("tc_frozen", r[1], 32'h1);
    chk("freeze_bit", r[4], 32'h1);
    debug_halt <= 1'b0;
    wr(OFF_CTRL, 32'h04);
  endtask : t_freeze

  task t_irq;
    logic [31:0] r;
    wait_uf;
    repeat (4) @(posedge pclk);
    chk("irq_masked", irq, 32'h0);
    wr(OFF_IRQ_MASK, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq_on", irq, 32'h1);
    slow_en <= 1'b0;
    rd(OFF_IRQ_STATUS, r);
    chk("stat_ufl", r[0], 32'h1);
    chk("stat_rst", r[1], 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq_off", irq, 32'h0);
    rd(OFF_IRQ_STATUS, r);
    chk("stat_clr", r, 32'h0);
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_prescale;
    t_period;
    t_freeze;
    t_irq;
    summarize;
  end

  initial begin
    #500000;
    n_fail++;
    summarize;
  end
endmodule : slow_tick_reload_timer_bench
